// ===== verif/rpf_far_side.sv
// far side model: host event drive, strap pin load and antenna status lines
`timescale 1ns/1ps
module rpf_far_side (
	input  wire logic short_in,
	input  wire logic absent_in,
	input  wire logic strap_low_in,
	input  wire logic event_in,
	output logic      fault_n_out,
	output logic      present_out,
	output logic      strap_out,
	output logic      event_out
);
	// released fault, present and strap lines rest at their pull-up level
	assign fault_n_out = !short_in;
	assign present_out = !absent_in;
	assign strap_out = !strap_low_in;
	assign event_out = event_in;
endmodule

// ===== verif/rpf_pins_sva.sv
// assertion checker for the receiver pin block, bound to its top
`timescale 1ns/1ps
module rpf_pins_sva (
	input wire logic                        ref_clk_in,
	input wire logic                        rst_in,
	input wire logic [5:0]                  avs_address_in,
	input wire logic                        avs_write_in,
	input wire logic [31:0]                 avs_writedata_in,
	input wire logic                        avs_waitrequest_out,
	input wire logic                        strap_pin_oe_out,
	input wire logic                        recovery_boot_out,
	input wire logic                        event_pullup_en_out,
	input wire logic [rpf_pkg::NUM_PIO-1:0] pio_out,
	input wire logic [rpf_pkg::NUM_PIO-1:0] pio_oe_out,
	input wire logic                        byte_queued_in,
	input wire logic                        byte_sent_in
);
	logic [31:0] pend;
	logic [31:0] ctrl;
	logic [12:0] lvl;
	logic        tk;
	logic        act;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	//////////////////////////////////////////////////////////////////////
	// shadow of config and buffer level, rebuilt from the port traffic
	assign tk = avs_write_in && !avs_waitrequest_out;
	assign act = pend[0] && (pio_out[pend[6:4]] == pend[1]);
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pend <= rpf_pkg::PEND_RST;
			ctrl <= rpf_pkg::CTRL_RST;
			lvl <= '0;
		end else begin
			if (tk && avs_address_in == rpf_pkg::ADDR_PEND_CFG) pend <= avs_writedata_in;
			if (tk && avs_address_in == rpf_pkg::ADDR_CTRL) ctrl <= avs_writedata_in;
			lvl <= lvl + 13'(byte_queued_in) - 13'(byte_sent_in);
		end
	end
	//////////////////////////////////////////////////////////////////////
	// margins of two cycles, up to four on the threshold check, cover the registered outputs
	a_boot_no_drive: assert property (recovery_boot_out |-> !strap_pin_oe_out)
		else $error("strap pin driven in recovery boot");
	a_tick_drive_run: assert property (!avs_waitrequest_out && !recovery_boot_out |-> strap_pin_oe_out)
		else $error("tick not driven in normal run");
	a_strap_latched: assert property (!avs_waitrequest_out |=> $stable(recovery_boot_out))
		else $error("boot mode moved after decision");
	a_pend_assert: assert property (pend[0] && pend[16:8] != 0 && lvl >= {pend[16:8], 3'h0} |-> ##[1:4] act)
		else $error("pending late at threshold");
	a_pend_hold: assert property (act && !tk && lvl > 13'h1 |=> act)
		else $error("pending dropped with bytes left");
	a_pend_idle_lvl: assert property (pend[0] && lvl == 0 && $past(lvl, 2) == 0 && $past(pend, 2) == pend
		|-> pio_out[pend[6:4]] == !pend[1]) else $error("pending idle level wrong");
	a_pend_oe_route: assert property (pend[0] && $past(pend, 2) == pend |-> pio_oe_out[pend[6:4]])
		else $error("pending pin not driven");
	a_pullup_onoff: assert property ($past(ctrl, 2) == ctrl |-> event_pullup_en_out == !ctrl[1])
		else $error("event pull-up wrong for mode");
	c_pend: cover property ($rose(act));
	c_boot: cover property ($rose(recovery_boot_out));
	c_host: cover property ($fell(event_pullup_en_out));
endmodule
bind rpf_pins rpf_pins_sva u_rpf_pins_sva (
	.ref_clk_in(ref_clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_waitrequest_out(avs_waitrequest_out),
	.strap_pin_oe_out(strap_pin_oe_out), .recovery_boot_out(recovery_boot_out),
	.event_pullup_en_out(event_pullup_en_out), .pio_out(pio_out), .pio_oe_out(pio_oe_out),
	.byte_queued_in(byte_queued_in), .byte_sent_in(byte_sent_in)
);

// ===== verif/rpf_pins_tb_top.sv
// self-checking bench for the receiver pin block
`timescale 1ns/1ps
module rpf_pins_tb_top;
	logic        ref_clk_in = 1'b0, rst_in = 1'b1, rd = 1'b0, wr = 1'b0, q = 1'b0, s = 1'b0;
	logic        evr = 1'b0, sh = 1'b0, ab = 1'b0, sl = 1'b0;
	logic        ev, fault_n, pres, strap_ext, strap_in, wt, strap_o, strap_oe, amp, sup_n, pu, boot, idl;
	logic [5:0]  adr = 6'h00;
	logic [31:0] wd = 32'h0, rdat, rdata;
	logic [7:0]  pin_i, pin_o, pin_oe, pin_pu;
	int          fail_count = 0, num_checks = 0;
	rpf_pins u_rpf_pins (
		.ref_clk_in(ref_clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wd), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
		.strap_pin_in(strap_in), .strap_pin_out(strap_o), .strap_pin_oe_out(strap_oe),
		.front_amp_power_on_out(amp), .antenna_supply_ctrl_n_out(sup_n), .external_event_input_in(ev),
		.event_pullup_en_out(pu), .pio_in(pin_i), .pio_out(pin_o), .pio_oe_out(pin_oe), .pio_pullup_out(pin_pu),
		.byte_queued_in(q), .byte_sent_in(s), .recovery_boot_out(boot), .interface_idle_out(idl)
	);
	rpf_far_side u_rpf_far_side (
		.short_in(sh), .absent_in(ab), .strap_low_in(sl), .event_in(evr),
		.fault_n_out(fault_n), .present_out(pres), .strap_out(strap_ext), .event_out(ev)
	);
	//////////////////////////////////////////////////////////////////////
	// wire level of shared pins: fault on pio 6, present on pio 5
	assign strap_in = strap_oe ? strap_o : strap_ext;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_i[i] = pin_oe[i] ? pin_o[i] : (i == 6) ? fault_n : (i == 5) ? pres : pin_pu[i];
		end
	end
	initial begin
		forever #2 ref_clk_in = ~ref_clk_in;
	end
	//////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic end_of_test();
		if (fail_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	// one bus access; request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		logic got;
		got = 1'b0;
		@(posedge ref_clk_in);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		for (int i = 0; i < 400 && !got; i++) begin
			@(posedge ref_clk_in);
			got = (wt === 1'b0);
			if (got) begin
				rdata = rdat;
			end
		end
		rd <= 1'b0;
		wr <= 1'b0;
		if (!got) begin
			chk1("bus wait", 1'b1, 1'b0);
			end_of_test();
		end
	endtask
	// one-cycle byte pulses with a gap, so each is counted alone
	task automatic bytes(input logic up, input int n);
		repeat (n) begin
			@(posedge ref_clk_in);
			q <= up;
			s <= !up;
			@(posedge ref_clk_in);
			q <= 1'b0;
			s <= 1'b0;
		end
	endtask
	// status poll, bounded; inputs pass a synchroniser first
	task automatic st_poll(input int b, input logic e, input string n);
		for (int i = 0; i < 16; i++) begin
			bus(1'b0, rpf_pkg::ADDR_STATUS, 32'h0);
			if (rdata[b] === e) break;
		end
		chk1(n, e, rdata[b]);
	endtask
	//////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		bus(1'b0, rpf_pkg::ADDR_CTRL, 32'h0);
		chk("ctrl", rpf_pkg::CTRL_RST, rdata);
		chk1("boot", 1'b0, boot);
		chk1("tick oe", 1'b1, strap_oe);
		chk1("tick level", 1'b1, strap_o);
		chk1("amp", 1'b1, amp);
		bus(1'b0, rpf_pkg::ADDR_PEND_CFG, 32'h0);
		chk("pend", rpf_pkg::PEND_RST, rdata);
		bus(1'b0, rpf_pkg::ADDR_ANT_CFG, 32'h0);
		chk("ant", rpf_pkg::ANT_RST, rdata);
		bus(1'b1, 6'h3c, 32'hffff_ffff);
		bus(1'b0, 6'h3c, 32'h0);
		chk("unmapped", rpf_pkg::UNMAPPED_DATA, rdata);
	endtask
	task automatic t_ctrl();
		logic [31:0] v [3] = '{32'h0, 32'h2, 32'h1};
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, rpf_pkg::ADDR_CTRL, v[i]);
			tick(3);
			chk1("amp", v[i][0], amp);
			chk1("pullup", !v[i][1], pu);
		end
	endtask
	// threshold of two chunks, indicator on pio 2
	task automatic t_pend();
		bus(1'b1, rpf_pkg::ADDR_PEND_CFG, 32'h0000_0223);
		bytes(1'b1, 15);
		tick(4);
		chk1("pend early", 1'b0, pin_o[2]);
		chk1("pend oe", 1'b1, pin_oe[2]);
		bytes(1'b1, 1);
		tick(4);
		chk1("pend on", 1'b1, pin_o[2]);
		bus(1'b0, rpf_pkg::ADDR_BUF_LEVEL, 32'h0);
		chk("level", 32'h10, rdata);
		bytes(1'b0, 15);
		tick(4);
		chk1("pend hold", 1'b1, pin_o[2]);
		bytes(1'b0, 1);
		tick(4);
		chk1("pend off", 1'b0, pin_o[2]);
		bus(1'b1, rpf_pkg::ADDR_PEND_CFG, 32'h0000_0221);
		tick(4);
		chk1("pend low pol idle", 1'b1, pin_o[2]);
	endtask
	task automatic t_ant();
		bus(1'b1, rpf_pkg::ADDR_ANT_CFG, 32'h0000_651f);
		st_poll(rpf_pkg::ST_PRESENT, 1'b1, "present");
		chk1("fault pullup", 1'b1, pin_pu[6]);
		sh <= 1'b1;
		st_poll(rpf_pkg::ST_SHORT, 1'b1, "short");
		tick(3);
		chk1("supply off", 1'b0, sup_n);
		sh <= 1'b0;
		ab <= 1'b1;
		st_poll(rpf_pkg::ST_OPEN, 1'b1, "open");
		bus(1'b1, rpf_pkg::ADDR_ANT_CFG, 32'h0000_651b);
		st_poll(rpf_pkg::ST_OPEN, 1'b0, "two pin open");
		bus(1'b1, rpf_pkg::ADDR_ANT_CFG, 32'h0000_650f);
		st_poll(rpf_pkg::ST_PRESENT, 1'b1, "present low pol");
	endtask
	task automatic t_event();
		bus(1'b1, rpf_pkg::ADDR_CTRL, 32'h0000_0005);
		evr <= 1'b1;
		st_poll(rpf_pkg::ST_EVENT, 1'b1, "event");
		st_poll(rpf_pkg::ST_SLEEP, 1'b0, "wake");
		evr <= 1'b0;
	endtask
	// long idle: interface idles only once the buffer holds 4 kB
	task automatic t_idle();
		bus(1'b1, rpf_pkg::ADDR_CTRL, 32'h0000_0009);
		bytes(1'b1, 4095);
		tick(3);
		chk1("idle early", 1'b0, idl);
		bytes(1'b1, 1);
		tick(3);
		chk1("long idle", 1'b1, idl);
	endtask
	// strap held low across a second reset, then let go
	task automatic t_boot();
		sl <= 1'b1;
		rst_in <= 1'b1;
		tick(4);
		rst_in <= 1'b0;
		bus(1'b0, rpf_pkg::ADDR_STATUS, 32'h0);
		chk1("boot status", 1'b1, rdata[rpf_pkg::ST_RECOVERY]);
		chk1("no tick", 1'b0, strap_oe);
		sl <= 1'b0;
		tick(4);
		chk1("boot held", 1'b1, boot);
	endtask
	initial begin
		tick(4);
		rst_in <= 1'b0;
		t_reset();
		t_ctrl();
		t_pend();
		t_ant();
		t_event();
		t_idle();
		t_boot();
		end_of_test();
	end
endmodule

// ===== verilog/rpf_pins.sv
// receiver special pin functions: strap, tick, amp power, event, pending, antenna supervisor
`timescale 1ns/1ps

module rpf_pins (
	input  wire logic                         ref_clk_in,
	input  wire logic                         rst_in,
	input  wire logic [5:0]                   avs_address_in,
	input  wire logic                         avs_read_in,
	input  wire logic                         avs_write_in,
	input  wire logic [31:0]                  avs_writedata_in,
	input  wire logic [3:0]                   avs_byteenable_in,
	output logic [31:0]                       avs_readdata_out,
	output logic                              avs_waitrequest_out,
	input  wire logic                         strap_pin_in,
	output logic                              strap_pin_out,
	output logic                              strap_pin_oe_out,
	output logic                              front_amp_power_on_out,
	output logic                              antenna_supply_ctrl_n_out,
	input  wire logic                         external_event_input_in,
	output logic                              event_pullup_en_out,
	input  wire logic [rpf_pkg::NUM_PIO-1:0]  pio_in,
	output logic [rpf_pkg::NUM_PIO-1:0]       pio_out,
	output logic [rpf_pkg::NUM_PIO-1:0]       pio_oe_out,
	output logic [rpf_pkg::NUM_PIO-1:0]       pio_pullup_out,
	input  wire logic                         byte_queued_in,
	input  wire logic                         byte_sent_in,
	output logic                              recovery_boot_out,
	output logic                              interface_idle_out
);

	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		BOOT_WAIT = 2'b00,
		BOOT_RUN  = 2'b01,
		BOOT_SAFE = 2'b10
	} rpf_boot_type;

	typedef struct packed {
		rpf_boot_type           boot;
		logic [31:0]            ctrl;
		logic [31:0]            pend_cfg;
		logic [31:0]            ant_cfg;
		logic [31:0]            pulse_cfg;
		logic [31:0]            rdata;
		logic                   wait_n;
		logic [rpf_pkg::NUM_PIO-1:0] pio_s1;
		logic [rpf_pkg::NUM_PIO-1:0] pio_s2;
		logic [1:0]             evt_s1;
		logic [1:0]             evt_s2;
		logic                   evt_prev;
		logic                   evt_seen;
		logic                   sleeping;
		logic [rpf_pkg::CNT_W-1:0] level;
		logic                   pending;
		logic [31:0]            idle_cnt;
		logic                   idle;
		logic [31:0]            tick_cnt;
		logic                   tick;
		logic                   present;
		logic                   shorted;
		logic                   open;
		logic                   supply_on;
		logic                   amp_on;
		logic [rpf_pkg::NUM_PIO-1:0] pout;
		logic [rpf_pkg::NUM_PIO-1:0] poe;
		logic [rpf_pkg::NUM_PIO-1:0] ppu;
		logic                   ev_pu;
		// boot settle count and flopped copies of the decoded outputs
		logic [1:0]             boot_arm;
		logic                   waitreq;
		logic                   tick_oe;
		logic                   safe;
	} rpf_state_type;

	rpf_state_type st;
	rpf_state_type next_st;

	// byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// pick a routed synchronised pin and apply its polarity
	function automatic logic routed(input logic [rpf_pkg::NUM_PIO-1:0] p, input logic [rpf_pkg::PIO_W-1:0] sel,
			input logic pol_hi);
		return pol_hi ? p[sel] : ~p[sel];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		logic [rpf_pkg::PIO_W-1:0] pend_pin;
		logic [rpf_pkg::PIO_W-1:0] det_pin;
		logic [rpf_pkg::PIO_W-1:0] flt_pin;
		logic [rpf_pkg::CNT_W-1:0] thr;
		logic                      host_act;
		logic                      run;
		logic                      fault;
		pend_pin = st.pend_cfg[rpf_pkg::PEND_PIN_LSB +: rpf_pkg::PIO_W];
		det_pin  = st.ant_cfg[rpf_pkg::ANT_DET_PIN +: rpf_pkg::PIO_W];
		flt_pin  = st.ant_cfg[rpf_pkg::ANT_FLT_PIN +: rpf_pkg::PIO_W];
		thr      = rpf_pkg::CNT_W'(st.pend_cfg[rpf_pkg::PEND_THR_LSB +: rpf_pkg::PEND_THR_W]) * rpf_pkg::CHUNK_BYTES;
		host_act = 1'b0;
		run      = (st.boot == BOOT_RUN);
		fault    = 1'b0;
		next_st  = st;

		// two-stage input synchronisers
		// only the second stage is read by the logic below, the first may be
		// metastable when a pin moves close to the clock edge
		next_st.pio_s1 = pio_in;
		next_st.pio_s2 = st.pio_s1;
		next_st.evt_s1 = {external_event_input_in, strap_pin_in};
		next_st.evt_s2 = st.evt_s1;
		next_st.evt_prev = st.evt_s2[1];

		// strap is judged once, on the third edge after release: the first edge
		// loads the sync chain, the second moves it to the stage that is read;
		// judging sooner would take the chain's reset value for a low strap
		case (st.boot)
			BOOT_WAIT: begin
				if (st.boot_arm[1]) begin
					next_st.boot = st.evt_s2[0] ? BOOT_RUN : BOOT_SAFE;
				end
				next_st.boot_arm = {st.boot_arm[0], 1'b1};
			end
			// decision is final until the next reset
			BOOT_RUN:  next_st.boot = BOOT_RUN;
			BOOT_SAFE: next_st.boot = BOOT_SAFE;
			default:   next_st.boot = BOOT_WAIT;
		endcase

		// avalon slave: a request is seen while wait_n is low, decoded once and
		// answered one edge later; the read word is latched at the first edge so
		// it already stands at the edge where the master samples waitrequest low
		next_st.wait_n = 1'b0;
		if ((avs_read_in || avs_write_in) && !st.wait_n && st.boot != BOOT_WAIT) begin
			next_st.wait_n = 1'b1;
			next_st.rdata  = 32'h0;
			case (avs_address_in)
				rpf_pkg::ADDR_CTRL: begin
					next_st.rdata = st.ctrl;
				end
				rpf_pkg::ADDR_PEND_CFG: begin
					next_st.rdata = st.pend_cfg;
				end
				rpf_pkg::ADDR_ANT_CFG: begin
					next_st.rdata = st.ant_cfg;
				end
				// level is read only, a live view of the outgoing buffer
				rpf_pkg::ADDR_BUF_LEVEL: begin
					next_st.rdata = 32'(st.level);
				end
				rpf_pkg::ADDR_STATUS: begin
					next_st.rdata[rpf_pkg::ST_RECOVERY] = (st.boot == BOOT_SAFE);
					next_st.rdata[rpf_pkg::ST_SLEEP]    = st.sleeping;
					next_st.rdata[rpf_pkg::ST_PRESENT]  = st.present;
					next_st.rdata[rpf_pkg::ST_SHORT]    = st.shorted;
					next_st.rdata[rpf_pkg::ST_OPEN]     = st.open;
					next_st.rdata[rpf_pkg::ST_PENDING]  = st.pending;
					next_st.rdata[rpf_pkg::ST_IDLE]     = st.idle;
					next_st.rdata[rpf_pkg::ST_SUPPLY]   = st.supply_on;
					next_st.rdata[rpf_pkg::ST_EVENT]    = st.evt_seen;
					// reading status clears the event flag unless a new edge lands now
					next_st.evt_seen = 1'b0;
				end
				rpf_pkg::ADDR_PULSE_CFG: begin
					next_st.rdata = st.pulse_cfg;
				end
				default: next_st.rdata = rpf_pkg::UNMAPPED_DATA;
			endcase
		end

		// writes land only at the answering edge, the one at which the master sees
		// waitrequest low; landing earlier would let config move before the
		// transfer is complete on the bus
		if (avs_write_in && st.wait_n) begin
			case (avs_address_in)
				rpf_pkg::ADDR_CTRL: begin
					next_st.ctrl = merge(st.ctrl, avs_writedata_in, avs_byteenable_in);
					// host access bit is a pulse, never stored
					host_act = avs_writedata_in[rpf_pkg::CTRL_HOST_ACCESS] & avs_byteenable_in[0];
					next_st.ctrl[rpf_pkg::CTRL_HOST_ACCESS] = 1'b0;
				end
				rpf_pkg::ADDR_PEND_CFG: begin
					next_st.pend_cfg = merge(st.pend_cfg, avs_writedata_in, avs_byteenable_in);
				end
				rpf_pkg::ADDR_ANT_CFG: begin
					next_st.ant_cfg = merge(st.ant_cfg, avs_writedata_in, avs_byteenable_in);
				end
				rpf_pkg::ADDR_PULSE_CFG: begin
					next_st.pulse_cfg = merge(st.pulse_cfg, avs_writedata_in, avs_byteenable_in);
				end
				// status, level and unmapped words take no write
				default: host_act = 1'b0;
			endcase
		end

		// event edge: sticky flag (set beats clear) and wake from sleep
		if (st.evt_s2[1] && !st.evt_prev) begin
			next_st.evt_seen = 1'b1;
		end
		next_st.sleeping = st.ctrl[rpf_pkg::CTRL_POWER_SAVE] & st.sleeping;
		if (st.ctrl[rpf_pkg::CTRL_POWER_SAVE] && !st.sleeping && !st.ctrl[rpf_pkg::CTRL_HOST_ONOFF]) begin
			next_st.sleeping = 1'b1;
		end
		if (st.evt_s2[1] && !st.evt_prev) begin
			next_st.sleeping = 1'b0;
			next_st.ctrl[rpf_pkg::CTRL_POWER_SAVE] = 1'b0;
		end
		// host on/off mode: event level itself keeps the receiver on
		if (st.ctrl[rpf_pkg::CTRL_HOST_ONOFF]) begin
			next_st.sleeping = ~st.evt_s2[1];
		end
		next_st.ev_pu = ~st.ctrl[rpf_pkg::CTRL_HOST_ONOFF];

		// outgoing buffer level, saturating at buffer size
		// a queue and a send in one cycle cancel, so the level stands still;
		// bytes queued beyond the buffer size are lost, as on a full buffer
		if (byte_queued_in && !byte_sent_in && st.level != rpf_pkg::BUF_BYTES) begin
			next_st.level = st.level + 1'b1;
		end else if (byte_sent_in && !byte_queued_in && st.level != '0) begin
			next_st.level = st.level - 1'b1;
		end

		// pending indicator: set at threshold, hold until the buffer is empty
		// a zero threshold flags any single byte; the per-interface buffer may
		// still hold bytes after the drop, so the host keeps reading
		if (!st.pend_cfg[rpf_pkg::PEND_EN]) begin
			next_st.pending = 1'b0;
		end else if (st.level >= thr && st.level != '0) begin
			next_st.pending = 1'b1;
		end else if (st.level == '0) begin
			next_st.pending = 1'b0;
		end

		// serial-bus idle timeout, long idle waits for a full buffer instead
		// any host write with the access bit, or any delivered byte, counts as
		// activity and restarts the count
		if (host_act || byte_sent_in) begin
			next_st.idle_cnt = '0;
			next_st.idle     = 1'b0;
		end else if (st.ctrl[rpf_pkg::CTRL_LONG_IDLE]) begin
			next_st.idle = (st.level == rpf_pkg::BUF_BYTES);
		end else if (st.idle_cnt >= 32'(rpf_pkg::IDLE_CYCLES)) begin
			next_st.idle = 1'b1;
		end else begin
			next_st.idle_cnt = st.idle_cnt + 32'h1;
		end

		// one-second tick
		// pulse width is the reset width plus the extra width set by software;
		// a width beyond the period leaves the pin high all the time
		if (st.tick_cnt >= 32'(rpf_pkg::TICK_CYCLES - 1)) begin
			next_st.tick_cnt = '0;
		end else begin
			next_st.tick_cnt = st.tick_cnt + 32'h1;
		end
		next_st.tick = (st.tick_cnt < st.pulse_cfg[31:0] + rpf_pkg::PULSE_W_RST);

		// antenna supervisor
		// present and fault inputs are picked from the synchronised pins, each
		// with its own polarity; open detect off gives the two-pin variant
		next_st.present = routed(st.pio_s2, det_pin, st.ant_cfg[rpf_pkg::ANT_DET_POL]);
		fault = routed(st.pio_s2, flt_pin, st.ant_cfg[rpf_pkg::ANT_FLT_POL]);
		next_st.shorted = st.ant_cfg[rpf_pkg::ANT_SHORTDET] & fault;
		next_st.open = st.ant_cfg[rpf_pkg::ANT_OPENDET] & ~next_st.present;
		next_st.supply_on = ~(st.ant_cfg[rpf_pkg::ANT_PWRDOWN] & st.shorted);

		// amp power follows control, off while sleeping, outside run, or with voltage control on and the supply off
		next_st.amp_on = st.ctrl[rpf_pkg::CTRL_AMP_ON] & ~next_st.sleeping & run;
		if (st.ant_cfg[rpf_pkg::ANT_VOLTCTRL]) begin
			next_st.amp_on = next_st.amp_on & next_st.supply_on;
		end

		// pio routing: supervisor inputs get pull-ups, pending pin is driven
		next_st.pout = '0;
		next_st.poe  = '0;
		next_st.ppu  = '1;
		if (st.pend_cfg[rpf_pkg::PEND_EN]) begin
			next_st.poe[pend_pin]  = 1'b1;
			next_st.ppu[pend_pin]  = 1'b0;
			// active high drives the flag as is, active low drives its inverse
			next_st.pout[pend_pin] = st.pend_cfg[rpf_pkg::PEND_POL_HI] ? next_st.pending : ~next_st.pending;
		end

		// flopped copies of decoded outputs, so every pin comes from a flip-flop
		// waitrequest stays high through boot settling and outside the answer cycle
		next_st.waitreq = ~next_st.wait_n | (next_st.boot == BOOT_WAIT);
		next_st.tick_oe = (next_st.boot == BOOT_RUN);
		next_st.safe    = (next_st.boot == BOOT_SAFE);
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	// reset branch loads constants only; waitrequest and pull-ups rest high
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			st           <= '0;
			st.boot      <= BOOT_WAIT;
			st.ctrl      <= rpf_pkg::CTRL_RST;
			st.pend_cfg  <= rpf_pkg::PEND_RST;
			st.ant_cfg   <= rpf_pkg::ANT_RST;
			st.pulse_cfg <= rpf_pkg::PULSE_RST;
			st.ppu       <= '1;
			st.ev_pu     <= 1'b1;
			st.supply_on <= 1'b1;
			st.pio_s1    <= '1;
			st.pio_s2    <= '1;
			st.waitreq   <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from state
	assign avs_readdata_out          = st.rdata;
	assign avs_waitrequest_out       = st.waitreq;
	assign strap_pin_out             = st.tick;
	assign strap_pin_oe_out          = st.tick_oe;
	assign front_amp_power_on_out    = st.amp_on;
	assign antenna_supply_ctrl_n_out = st.amp_on; // active low off: copy of amp_on, so the supply is kept on only while amp power is on
	assign event_pullup_en_out       = st.ev_pu;
	assign pio_out                   = st.pout;
	assign pio_oe_out                = st.poe;
	assign pio_pullup_out            = st.ppu;
	assign recovery_boot_out         = st.safe;
	assign interface_idle_out        = st.idle;

endmodule

// ===== verilog/rpf_pkg.sv
// package: register map, field positions, reset values and timing of the receiver pin block
package rpf_pkg;
	// avalon register byte offsets
	localparam logic [5:0] ADDR_CTRL      = 6'h00;
	localparam logic [5:0] ADDR_PEND_CFG  = 6'h04;
	localparam logic [5:0] ADDR_ANT_CFG   = 6'h08;
	localparam logic [5:0] ADDR_BUF_LEVEL = 6'h0c;
	localparam logic [5:0] ADDR_STATUS    = 6'h10;
	localparam logic [5:0] ADDR_PULSE_CFG = 6'h14;
	// ctrl fields
	localparam int CTRL_AMP_ON      = 0;
	localparam int CTRL_HOST_ONOFF  = 1;
	localparam int CTRL_POWER_SAVE  = 2;
	localparam int CTRL_LONG_IDLE   = 3;
	localparam int CTRL_HOST_ACCESS = 4;
	// pending cfg fields
	localparam int PEND_EN      = 0;
	localparam int PEND_POL_HI  = 1;
	localparam int PEND_PIN_LSB = 4;
	localparam int PEND_THR_LSB = 8;
	localparam int PEND_THR_W   = 9;
	// antenna cfg fields
	localparam int ANT_VOLTCTRL = 0;
	localparam int ANT_SHORTDET = 1;
	localparam int ANT_OPENDET  = 2;
	localparam int ANT_PWRDOWN  = 3;
	localparam int ANT_DET_POL  = 4;
	localparam int ANT_FLT_POL  = 5;
	localparam int ANT_DET_PIN  = 8;
	localparam int ANT_FLT_PIN  = 12;
	// status fields
	localparam int ST_RECOVERY = 0;
	localparam int ST_SLEEP    = 1;
	localparam int ST_PRESENT  = 2;
	localparam int ST_SHORT    = 3;
	localparam int ST_OPEN     = 4;
	localparam int ST_PENDING  = 5;
	localparam int ST_IDLE     = 6;
	localparam int ST_SUPPLY   = 7;
	localparam int ST_EVENT    = 8;
	// widths and reset values
	localparam int NUM_PIO = 8;
	localparam int PIO_W   = 3;
	localparam int CNT_W   = 13;
	localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
	localparam logic [31:0] PEND_RST     = 32'h0000_0000;
	localparam logic [31:0] ANT_RST      = 32'h0000_0001;
	localparam logic [31:0] PULSE_RST    = 32'h0000_0000;
	localparam logic [31:0] PULSE_W_RST  = 32'h0000_0019;
	localparam logic [CNT_W-1:0] CHUNK_BYTES = 13'h0008; // threshold unit
	localparam logic [CNT_W-1:0] BUF_BYTES   = 13'h1000; // 4 kB
	localparam logic [CNT_W-1:0] PORT_BUF    = 13'h0010; // 16-byte per-interface buffer
	// timing
	localparam longint CLK_HZ      = 250_000_000;
	localparam longint IDLE_MS     = 1500;
	localparam longint IDLE_CYCLES = CLK_HZ * IDLE_MS / 1000;
	localparam longint TICK_CYCLES = CLK_HZ;
	localparam logic [31:0] UNMAPPED_DATA = 32'hdead_0000;
endpackage
